// file: rtl/sysctl_pkg.sv
// Summary of operation
// - Any of four sources asserts chip reset
// - Hold reset until pin, oscillator, count, flash
// - Processor starts at address zero on release
// - Boot address and vector base hold reset values before release
// - First brownout stage raises interrupt request
// - Interrupt gated by enable, status always readable
// - Second brownout stage asserts chip reset
// - Brownout reset hands over to power-on reset
// - Both brownout thresholds use hysteresis
// - Protection level decoded from flash pattern
// - In-app flash calls allowed at every level
// - Level one blocks debug, protects sector zero
// - Level two blocks debug, allows chip erase and writes outside sector zero
// - Level three blocks debug and ISP, ignores boot override
// - Thirty edge inputs, one level wake input
`default_nettype none
package sysctl_pkg;
    localparam int CLK_MHZ = 250;
    localparam int RESET_HOLD_NS = 1000;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int HYST_NS = 400;
    localparam int HYST_CYC = (HYST_NS * CLK_MHZ + 999) / 1000;
    localparam int EDGE_IRQS = 30;
    localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
    localparam logic [31:0] GUARD_PAT_ONE = 32'h1234_5678;
    localparam logic [31:0] GUARD_PAT_TWO = 32'h8765_4321;
    localparam logic [31:0] GUARD_PAT_THREE = 32'h4321_8765;
    localparam logic [31:0] VTOR_LIMIT = 32'h4000_0000;
    localparam logic [31:0] VTOR_ALIGN_MASK = 32'h0000_01FF;
    typedef enum logic [1:0] {
        GUARD_NONE,
        GUARD_ONE,
        GUARD_TWO,
        GUARD_THREE
    } guard_level_t;
    typedef enum {
        ST_HOLD,
        ST_COUNT,
        ST_FLASH,
        ST_RUN
    } rst_state_t;
endpackage : sysctl_pkg
`default_nettype wire

// file: rtl/sync_filter.sv
`default_nettype none
module sync_filter #(
    parameter int HOLD = 1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_async,
    output logic o_level
);
    logic meta_ff;
    logic sync_ff;
    logic [15:0] cnt_ff;
    logic level_ff;
    logic differs;
    logic done;

    assign differs = sync_ff != level_ff;
    assign done = cnt_ff == 16'(HOLD - 1);
    assign o_level = level_ff;

    always_ff @(posedge i_mclk) begin
        meta_ff <= i_async;
        sync_ff <= meta_ff;
    end

    // Output changes only after the new level is steady for HOLD cycles
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            cnt_ff <= 16'h0000;
            level_ff <= 1'b0;
        end else if (!differs) begin
            cnt_ff <= 16'h0000;
        end else if (done) begin
            cnt_ff <= 16'h0000;
            level_ff <= sync_ff;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
endmodule : sync_filter
`default_nettype wire

// file: rtl/reset_brownout_guard_control.sv
`default_nettype none
module reset_brownout_guard_control
    import sysctl_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_reset_pin_n,
    input wire logic i_watchdog_rst,
    input wire logic i_por,
    input wire logic i_bod_irq_cmp,
    input wire logic i_bod_rst_cmp,
    input wire logic i_osc_ok,
    input wire logic i_flash_init_done,
    input wire logic [31:0] i_guard_word,
    input wire logic i_boot_override_pin_n,
    input wire logic i_brownout_irq_en,
    input wire logic i_isp_erase_all,
    input wire logic i_isp_write,
    input wire logic [4:0] i_isp_sector,
    input wire logic i_iap_req,
    input wire logic [EDGE_IRQS-1:0] i_edge_irq_pin,
    input wire logic [EDGE_IRQS-1:0] i_edge_irq_sel,
    input wire logic i_ext_irq_pin,
    input wire logic i_ext_wake_en,
    input wire logic i_powered_down,
    input wire logic [31:0] i_vtor_wr_data,
    input wire logic i_vtor_wr,
    output logic o_chip_rst_n,
    output logic o_flash_init_start,
    output logic [31:0] o_boot_addr,
    output logic o_brownout_irq,
    output logic o_brownout_status,
    output sysctl_pkg::guard_level_t o_guard_level,
    output logic o_debug_allow,
    output logic o_isp_allow,
    output logic o_isp_cmd_ok,
    output logic o_iap_allow,
    output logic o_isp_enter,
    output logic [EDGE_IRQS-1:0] o_edge_irq,
    output logic o_ext_irq,
    output logic o_wake,
    output logic [31:0] o_vtor,
    output logic o_vtor_err
);
    import sysctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and brownout hysteresis
    logic pin_rst_lvl;
    logic bod_irq_lvl;
    logic bod_rst_lvl;
    logic osc_lvl;
    logic ext_lvl;
    logic boot_lvl;

    sync_filter #(.HOLD(1)) u_pin (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(~i_reset_pin_n),
        .o_level(pin_rst_lvl)
    );
    sync_filter #(.HOLD(HYST_CYC)) u_bod_irq (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(i_bod_irq_cmp),
        .o_level(bod_irq_lvl)
    );
    sync_filter #(.HOLD(HYST_CYC)) u_bod_rst (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(i_bod_rst_cmp),
        .o_level(bod_rst_lvl)
    );
    sync_filter #(.HOLD(1)) u_osc (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(i_osc_ok),
        .o_level(osc_lvl)
    );
    sync_filter #(.HOLD(1)) u_ext (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(i_ext_irq_pin),
        .o_level(ext_lvl)
    );
    sync_filter #(.HOLD(1)) u_boot (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_async(~i_boot_override_pin_n),
        .o_level(boot_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset merge and release sequencer
    rst_state_t state_ff;
    rst_state_t nxt_state;
    logic [15:0] hold_cnt_ff;
    logic [15:0] nxt_hold_cnt;
    logic any_src;
    logic hold_done;

    // Brownout reset stays on the whole way down; power-on reset overlaps
    assign any_src = pin_rst_lvl | i_watchdog_rst | i_por |
                     bod_rst_lvl;
    assign hold_done = hold_cnt_ff == 16'(RESET_HOLD_CYC - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_hold_cnt = 16'h0000;
        case (state_ff)
            ST_HOLD: begin
                if (!any_src && osc_lvl) begin
                    nxt_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                nxt_hold_cnt = hold_cnt_ff + 16'h0001;
                if (hold_done) begin
                    nxt_state = ST_FLASH;
                end
            end
            ST_FLASH: begin
                if (i_flash_init_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
        if (any_src || !osc_lvl) begin
            nxt_state = ST_HOLD;
            nxt_hold_cnt = 16'h0000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_ff <= ST_HOLD;
            hold_cnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end

    logic chip_rst_n_ff;
    logic flash_start_ff;
    logic running;

    assign running = state_ff == ST_RUN;
    assign o_chip_rst_n = chip_rst_n_ff;
    assign o_flash_init_start = flash_start_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            chip_rst_n_ff <= 1'b0;
            flash_start_ff <= 1'b0;
        end else begin
            chip_rst_n_ff <= nxt_state == ST_RUN;
            flash_start_ff <= nxt_state == ST_FLASH;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot address and guard level latch
    logic [31:0] boot_addr_ff;
    guard_level_t guard_ff;
    guard_level_t guard_dec;

    function automatic guard_level_t decode_guard(input logic [31:0] w);
        if (w == GUARD_PAT_ONE) begin
            decode_guard = GUARD_ONE;
        end else if (w == GUARD_PAT_TWO) begin
            decode_guard = GUARD_TWO;
        end else if (w == GUARD_PAT_THREE) begin
            decode_guard = GUARD_THREE;
        end else begin
            decode_guard = GUARD_NONE;
        end
    endfunction : decode_guard

    assign guard_dec = decode_guard(i_guard_word);
    assign o_boot_addr = boot_addr_ff;
    assign o_guard_level = guard_ff;

    // Boot address is reset while the chip is held in reset; guard level keeps its value until flash init done
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            boot_addr_ff <= BOOT_ADDR;
            guard_ff <= GUARD_NONE;
        end else if (!running) begin
            boot_addr_ff <= BOOT_ADDR;
            if (state_ff == ST_FLASH && i_flash_init_done) begin
                guard_ff <= guard_dec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access gating
    logic debug_ok;
    logic isp_ok;
    logic cmd_ok;
    logic debug_ff;
    logic isp_ff;
    logic cmd_ff;
    logic iap_ff;
    logic isp_enter_ff;

    assign debug_ok = guard_ff == GUARD_NONE;
    assign isp_ok = guard_ff != GUARD_THREE;
    assign cmd_ok = (guard_ff == GUARD_NONE) ||
        (guard_ff == GUARD_ONE && i_isp_write &&
         i_isp_sector != 5'h00) ||
        (guard_ff == GUARD_TWO && (i_isp_erase_all ||
         (i_isp_write && i_isp_sector != 5'h00)));
    assign o_debug_allow = debug_ff;
    assign o_isp_allow = isp_ff;
    assign o_isp_cmd_ok = cmd_ff;
    assign o_iap_allow = iap_ff;
    assign o_isp_enter = isp_enter_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            debug_ff <= 1'b0;
            isp_ff <= 1'b0;
            cmd_ff <= 1'b0;
            iap_ff <= 1'b0;
            isp_enter_ff <= 1'b0;
        end else begin
            debug_ff <= running && debug_ok;
            isp_ff <= running && isp_ok;
            cmd_ff <= running && isp_ok && cmd_ok;
            iap_ff <= running && i_iap_req;
            isp_enter_ff <= running && isp_ok && boot_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Brownout interrupt, external interrupts and wake
    logic bod_irq_ff;
    logic bod_stat_ff;
    logic [EDGE_IRQS-1:0] edge_meta_ff;
    logic [EDGE_IRQS-1:0] edge_sync_ff;
    logic [EDGE_IRQS-1:0] edge_prev_ff;
    logic [EDGE_IRQS-1:0] edge_irq_ff;
    logic ext_irq_ff;
    logic wake_ff;

    assign o_brownout_irq = bod_irq_ff;
    assign o_brownout_status = bod_stat_ff;
    assign o_edge_irq = edge_irq_ff;
    assign o_ext_irq = ext_irq_ff;
    assign o_wake = wake_ff;

    always_ff @(posedge i_mclk) begin
        edge_meta_ff <= i_edge_irq_pin;
        edge_sync_ff <= edge_meta_ff;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            bod_irq_ff <= 1'b0;
            bod_stat_ff <= 1'b0;
            edge_prev_ff <= '0;
            edge_irq_ff <= '0;
            ext_irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            bod_irq_ff <= bod_irq_lvl && i_brownout_irq_en;
            bod_stat_ff <= bod_irq_lvl;
            edge_prev_ff <= edge_sync_ff;
            edge_irq_ff <= edge_sync_ff & ~edge_prev_ff &
                           i_edge_irq_sel;
            ext_irq_ff <= ext_lvl;
            wake_ff <= ext_lvl && i_ext_wake_en && i_powered_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector table base check
    logic [31:0] vtor_ff;
    logic vtor_err_ff;
    logic vtor_bad;

    assign vtor_bad = (i_vtor_wr_data >= VTOR_LIMIT) ||
        ((i_vtor_wr_data & VTOR_ALIGN_MASK) != 32'h0000_0000);
    assign o_vtor = vtor_ff;
    assign o_vtor_err = vtor_err_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            vtor_ff <= 32'h0000_0000;
            vtor_err_ff <= 1'b0;
        end else if (!running) begin
            vtor_ff <= 32'h0000_0000;
            vtor_err_ff <= 1'b0;
        end else if (i_vtor_wr) begin
            vtor_err_ff <= vtor_bad;
            if (!vtor_bad) begin
                vtor_ff <= i_vtor_wr_data;
            end
        end
    end
endmodule : reset_brownout_guard_control
`default_nettype wire

// file: verification/rbgc_sva.sv
`default_nettype none
module rbgc_sva
    import sysctl_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_watchdog_rst,
    input wire logic i_por,
    input wire logic i_bod_irq_cmp,
    input wire logic i_flash_init_done,
    input wire logic i_brownout_irq_en,
    input wire logic i_vtor_wr,
    input wire logic [31:0] i_vtor_wr_data,
    input wire logic o_chip_rst_n,
    input wire logic o_flash_init_start,
    input wire logic [31:0] o_boot_addr,
    input wire logic o_brownout_irq,
    input wire logic o_brownout_status,
    input wire sysctl_pkg::guard_level_t o_guard_level,
    input wire logic o_debug_allow,
    input wire logic o_isp_allow,
    input wire logic o_isp_enter,
    input wire logic o_vtor_err
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    wdog_rst_a: assert property (
        i_watchdog_rst |-> ##[1:2] !o_chip_rst_n) else $error("no reset");
    por_hold_a: assert property (
        i_por |-> ##[1:2] !o_chip_rst_n) else $error("por no reset");
    release_a: assert property (
        $rose(o_chip_rst_n) |-> $past(o_flash_init_start)
        && $past(i_flash_init_done)) else $error("early release");
    boot_addr_a: assert property (
        o_boot_addr == BOOT_ADDR) else $error("boot address");
    irq_gate_a: assert property (
        o_brownout_irq |-> o_brownout_status && $past(i_brownout_irq_en))
        else $error("irq not gated");
    hyst_a: assert property (
        $rose(o_brownout_status) |-> $past(i_bod_irq_cmp, 100))
        else $error("no filter");
    debug_gate_a: assert property (
        o_debug_allow |-> $past(o_guard_level) == GUARD_NONE)
        else $error("debug open");
    level3_block_a: assert property (
        o_guard_level == GUARD_THREE |-> !o_debug_allow && !o_isp_allow
        && !o_isp_enter) else $error("level three open");
    guard_hold_a: assert property (
        o_chip_rst_n && $past(o_chip_rst_n) |-> $stable(o_guard_level))
        else $error("guard changed");
    vtor_align_a: assert property (
        o_chip_rst_n && i_vtor_wr && i_vtor_wr_data[8:0] != 9'h000
        |=> o_vtor_err) else $error("misaligned accepted");
    cover property ($rose(o_chip_rst_n));
    cover property (o_brownout_irq);
    cover property (o_vtor_err);
endmodule : rbgc_sva
`default_nettype wire

// file: verification/flash_model.sv
`default_nettype none
module flash_model (
    input wire logic i_mclk,
    input wire logic i_start,
    input wire logic [31:0] i_pat,
    input wire logic [7:0] i_dly,
    output logic o_done,
    output logic [31:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    // Word is only valid while done; otherwise show its inverse
    always @(negedge i_mclk) begin
        cnt <= i_start ? cnt + 8'h01 : 8'h00;
        o_done <= i_start && cnt >= i_dly;
        o_word <= (i_start && cnt >= i_dly) ? i_pat : ~i_pat;
    end
endmodule : flash_model
`default_nettype wire

// file: verification/reset_brownout_guard_control_test.sv
`default_nettype none
module reset_brownout_guard_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sysctl_pkg::*;
    logic i_mclk = 1'h0, i_rstn = 1'h0, i_reset_pin_n = 1'h1;
    logic i_watchdog_rst = 1'h0, i_por = 1'h0, i_osc_ok = 1'h1;
    logic i_bod_irq_cmp = 1'h0, i_bod_rst_cmp = 1'h0, i_iap_req = 1'h1;
    logic i_boot_override_pin_n = 1'h0, i_brownout_irq_en = 1'h0;
    logic i_isp_erase_all = 1'h0, i_isp_write = 1'h0, i_vtor_wr = 1'h0;
    logic i_ext_irq_pin = 1'h0, i_ext_wake_en = 1'h0;
    logic i_powered_down = 1'h0, i_flash_init_done;
    logic [4:0] i_isp_sector = 5'h00;
    logic [7:0] dly = 8'h01;
    logic [31:0] i_guard_word, pat = 32'h0, i_vtor_wr_data = 32'h0;
    logic [EDGE_IRQS-1:0] i_edge_irq_pin = '0, i_edge_irq_sel = '0;
    logic [EDGE_IRQS-1:0] o_edge_irq;
    logic [31:0] o_boot_addr, o_vtor;
    logic o_chip_rst_n, o_flash_init_start, o_brownout_irq;
    logic o_brownout_status, o_debug_allow, o_isp_allow, o_isp_cmd_ok;
    logic o_iap_allow, o_isp_enter, o_ext_irq, o_wake, o_vtor_err;
    guard_level_t o_guard_level;
    int mismatches = 0, n_tests = 0;

    reset_brownout_guard_control dut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reset_pin_n(i_reset_pin_n),
        .i_watchdog_rst(i_watchdog_rst), .i_por(i_por),
        .i_bod_irq_cmp(i_bod_irq_cmp), .i_bod_rst_cmp(i_bod_rst_cmp),
        .i_osc_ok(i_osc_ok), .i_flash_init_done(i_flash_init_done),
        .i_guard_word(i_guard_word),
        .i_boot_override_pin_n(i_boot_override_pin_n),
        .i_brownout_irq_en(i_brownout_irq_en),
        .i_isp_erase_all(i_isp_erase_all), .i_isp_write(i_isp_write),
        .i_isp_sector(i_isp_sector), .i_iap_req(i_iap_req),
        .i_edge_irq_pin(i_edge_irq_pin), .i_edge_irq_sel(i_edge_irq_sel),
        .i_ext_irq_pin(i_ext_irq_pin), .i_ext_wake_en(i_ext_wake_en),
        .i_powered_down(i_powered_down), .i_vtor_wr_data(i_vtor_wr_data),
        .i_vtor_wr(i_vtor_wr), .o_chip_rst_n(o_chip_rst_n),
        .o_flash_init_start(o_flash_init_start), .o_boot_addr(o_boot_addr),
        .o_brownout_irq(o_brownout_irq),
        .o_brownout_status(o_brownout_status),
        .o_guard_level(o_guard_level), .o_debug_allow(o_debug_allow),
        .o_isp_allow(o_isp_allow), .o_isp_cmd_ok(o_isp_cmd_ok),
        .o_iap_allow(o_iap_allow), .o_isp_enter(o_isp_enter),
        .o_edge_irq(o_edge_irq), .o_ext_irq(o_ext_irq), .o_wake(o_wake),
        .o_vtor(o_vtor), .o_vtor_err(o_vtor_err)
    );
    flash_model partner (.i_mclk(i_mclk), .i_start(o_flash_init_start),
        .i_pat(pat), .i_dly(dly), .o_done(i_flash_init_done),
        .o_word(i_guard_word));

    initial begin
        forever #2 i_mclk = ~i_mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : cyc

    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Reboot through the watchdog, then probe every gated access
    task automatic boot(input logic [31:0] w, input guard_level_t lv,
                        input logic [7:0] d);
        int k;
        pat = w;
        dly = d;
        i_watchdog_rst = 1'h1;
        cyc(3);
        chk(o_chip_rst_n, 1'h0);
        i_watchdog_rst = 1'h0;
        for (k = 0; k < 600 && !o_flash_init_start; k++) cyc(1);
        chk(k, RESET_HOLD_CYC + 1);
        chk(o_chip_rst_n, 1'h0);
        for (k = 0; k < 300 && !o_chip_rst_n; k++) cyc(1);
        chk(k, d + 32'h0000_0001);
        chk(o_chip_rst_n, 1'h1);
        i_isp_write = 1'h1;
        cyc(3);
        chk(o_guard_level, lv);
        chk(o_vtor, 32'h0000_0000);
        chk(o_isp_allow, lv != GUARD_THREE);
        chk(o_boot_addr, BOOT_ADDR);
        chk(o_isp_cmd_ok, lv == GUARD_NONE);
        chk(o_debug_allow, lv == GUARD_NONE);
        chk(o_iap_allow, 1'h1);
        chk(o_isp_enter, lv != GUARD_THREE);
        i_isp_sector = 5'h05;
        cyc(3);
        chk(o_isp_cmd_ok, lv != GUARD_THREE);
        i_isp_write = 1'h0;
        i_isp_erase_all = 1'h1;
        cyc(3);
        chk(o_isp_cmd_ok, lv == GUARD_NONE || lv == GUARD_TWO);
        i_isp_erase_all = 1'h0;
        i_isp_sector = 5'h00;
        pat = ~w;
        cyc(2);
        chk(o_guard_level, lv);
        $display("boot level %0d done", lv);
    endtask : boot

    task automatic t_brown;
        i_bod_irq_cmp = 1'h1;
        cyc(50);
        i_bod_irq_cmp = 1'h0;
        cyc(5);
        chk(o_brownout_status, 1'h0);
        i_bod_irq_cmp = 1'h1;
        cyc(HYST_CYC + 8);
        chk(o_brownout_status, 1'h1);
        chk(o_brownout_irq, 1'h0);
        i_brownout_irq_en = 1'h1;
        cyc(3);
        chk(o_brownout_irq, 1'h1);
        i_bod_irq_cmp = 1'h0;
        i_bod_rst_cmp = 1'h1;
        cyc(HYST_CYC + 8);
        chk(o_chip_rst_n, 1'h0);
        i_por = 1'h1;
        i_bod_rst_cmp = 1'h0;
        cyc(HYST_CYC + 8);
        chk(o_chip_rst_n, 1'h0);
        i_por = 1'h0;
        i_reset_pin_n = 1'h0;
        cyc(8);
        chk(o_chip_rst_n, 1'h0);
        i_reset_pin_n = 1'h1;
        $display("brownout and pin done");
    endtask : t_brown

    task automatic vwr(input logic [31:0] d, exp, input logic e);
        i_vtor_wr_data = d;
        i_vtor_wr = 1'h1;
        cyc(1);
        i_vtor_wr = 1'h0;
        cyc(2);
        chk(o_vtor, exp);
        chk(o_vtor_err, e);
    endtask : vwr

    // Vector base writes, then an oscillator loss while running
    task automatic t_vtor;
        vwr(32'h0000_0200, 32'h0000_0200, 1'h0);
        vwr(32'h0000_0204, 32'h0000_0200, 1'h1);
        vwr(VTOR_LIMIT, 32'h0000_0200, 1'h1);
        vwr(32'h3FFF_FE00, 32'h3FFF_FE00, 1'h0);
        i_osc_ok = 1'h0;
        cyc(6);
        chk(o_chip_rst_n, 1'h0);
        i_osc_ok = 1'h1;
        $display("vector base and oscillator done");
    endtask : t_vtor

    task automatic t_irq;
        int n;
        n = 0;
        i_edge_irq_sel = 30'h0000_0009;
        i_edge_irq_pin = 30'h0000_000B;
        repeat (8) begin
            cyc(1);
            n += $countones(o_edge_irq);
        end
        chk(n, 2);
        i_ext_irq_pin = 1'h1;
        i_ext_wake_en = 1'h1;
        i_powered_down = 1'h1;
        cyc(5);
        chk(o_ext_irq, 1'h1);
        chk(o_wake, 1'h1);
        i_ext_irq_pin = 1'h0;
        $display("interrupt inputs done");
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        i_rstn = 1'h1;
        boot(32'h0000_0000, GUARD_NONE, 8'h01);
        t_irq;
        t_vtor;
        boot(GUARD_PAT_ONE, GUARD_ONE, 8'h1E);
        t_brown;
        boot(GUARD_PAT_TWO, GUARD_TWO, 8'h03);
        boot(GUARD_PAT_THREE, GUARD_THREE, 8'h00);
        print_verdict();
    end

    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule : reset_brownout_guard_control_test

bind reset_brownout_guard_control rbgc_sva checker_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_watchdog_rst(i_watchdog_rst),
    .i_por(i_por), .i_bod_irq_cmp(i_bod_irq_cmp),
    .i_flash_init_done(i_flash_init_done),
    .i_brownout_irq_en(i_brownout_irq_en), .i_vtor_wr(i_vtor_wr),
    .i_vtor_wr_data(i_vtor_wr_data), .o_chip_rst_n(o_chip_rst_n),
    .o_flash_init_start(o_flash_init_start), .o_boot_addr(o_boot_addr),
    .o_brownout_irq(o_brownout_irq),
    .o_brownout_status(o_brownout_status),
    .o_guard_level(o_guard_level), .o_debug_allow(o_debug_allow),
    .o_isp_allow(o_isp_allow), .o_isp_enter(o_isp_enter),
    .o_vtor_err(o_vtor_err)
);
`default_nettype wire
